// ==== core/rat_pkg.sv ====
// package for the alarm threshold register block: command codes, field layout, reset values
// assumes the register port is a serial select/clock/data link sampled on core_clk
package rat_pkg;
    // command byte fields
    localparam int CMD_RD_BIT = 7;
    localparam int CMD_RAM_BIT = 6;
    localparam int CMD_ONE_BIT = 0;
    localparam logic [4:0] CMD_ADDR_MASK = 5'h1F;
    // register codes (bits 5:1 of the command byte)
    localparam logic [4:0] REG_MATCH_SEL = 5'h0A;
    localparam logic [4:0] REG_RESERVED = 5'h0B;
    localparam logic [4:0] REG_SEC_LIM = 5'h0C;
    localparam logic [4:0] REG_MIN_LIM = 5'h0D;
    localparam logic [4:0] REG_HR_LIM = 5'h0E;
    localparam logic [4:0] REG_DATE_LIM = 5'h0F;
    localparam logic [4:0] REG_MON_LIM = 5'h10;
    localparam logic [4:0] REG_WDAY_LIM = 5'h11;
    localparam logic [4:0] REG_YEAR_LIM = 5'h12;
    // match-select bit positions
    localparam int SEL_SEC = 0;
    localparam int SEL_MIN = 1;
    localparam int SEL_HR = 2;
    localparam int SEL_DATE = 3;
    localparam int SEL_MON = 4;
    localparam int SEL_WDAY = 5;
    localparam int SEL_YEAR = 6;
    // writable bit masks
    localparam logic [7:0] MASK_SEL = 8'h7F;
    localparam logic [7:0] MASK_SEC = 8'h7F;
    localparam logic [7:0] MASK_MIN = 8'h7F;
    localparam logic [7:0] MASK_HR = 8'hBF;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MON = 8'h1F;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    // hours field
    localparam int HR_MODE12_BIT = 7;
    localparam int HR_PM_BIT = 5;
    // reset values
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [7:0] RST_RESERVED = 8'h07;
    localparam logic [7:0] RST_SEC = 8'h7F;
    localparam logic [7:0] RST_MIN = 8'h7F;
    localparam logic [7:0] RST_HR = 8'hBF;
    localparam logic [7:0] RST_DATE = 8'h3F;
    localparam logic [7:0] RST_MON = 8'h1F;
    localparam logic [7:0] RST_WDAY = 8'h07;
    localparam logic [7:0] RST_YEAR = 8'hFF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int NUM_LIM = 7;

    typedef enum logic [2:0] {
        RAT_IDLE = 3'b001,
        RAT_CMD = 3'b010,
        RAT_DATA = 3'b100
    } rat_state_t;
endpackage

// ==== core/rat_alarm_regs.sv ====
// alarm match-select and BCD threshold registers behind a serial command port
// assumes spi_cs_n, spi_sclk, spi_din are already synchronous to core_clk and slow vs it
// and that the host raises spi_cs_n between accesses

// Contract
// RQ1 - match-select reads 0 in bit 7, bits 6..0 enable year..second matching, all clear at reset.
// RQ2 - the host never writes the reserved register, which reads a fixed pattern with 3 low ones.
// RQ3 - seconds and minutes limits hold bcd 00-59, tens in bits 6:4, units in 3:0, bit 7 zero.
// RQ4 - hours limit bit 7 selects 12-hour mode, in which bit 5 is the pm flag.
// RQ5 - hours limit resets with bit 7 set, bit 6 clear and bits 5..0 set.
// RQ6 - date limit holds bcd tens in bits 5:4 and units in bits 3:0, with bits 7:6 reading zero.
// RQ7 - month limit holds bcd 01-12, tens in bit 4, bits 7:5 zero, used bits set at reset.
// RQ8 - year limit holds bcd 00-99 in all eight bits, all of them set at reset.
// RQ9 - each access opens with a command byte msb first: bit 7 high reads, bit 6 high picks ram.
// RQ10 - command bit 0 must be one, and a write with it at zero is ignored.
// RQ11 - alarm_hit is set when at least one limit is enabled and every enabled limit equals its current time field.
module rat_alarm_regs
    import rat_pkg::*;
(
    input wire logic core_clk, // 200 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic spi_cs_n, // chip select, active low
    input wire logic spi_sclk, // serial clock
    input wire logic spi_din, // serial data in
    output logic spi_dout, // serial data out
    output logic spi_dout_oe, // high while dout drives
    input wire logic [7:0] now_sec, // current seconds, bcd
    input wire logic [7:0] now_min, // current minutes, bcd
    input wire logic [7:0] now_hr, // current hours, same format as threshold
    input wire logic [7:0] now_date, // current date, bcd
    input wire logic [7:0] now_mon, // current month, bcd
    input wire logic [7:0] now_wday, // current weekday
    input wire logic [7:0] now_year, // current year, bcd
    output logic alarm_hit // all enabled fields match, at least one enabled
);
    import rat_pkg::*;

    typedef struct packed {
        rat_state_t st;
        logic sclk;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic [7:0] cmd;
        logic [7:0] tx;
        logic dout;
        logic oe;
        logic [7:0] sel;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
        logic [7:0] date;
        logic [7:0] mon;
        logic [7:0] wday;
        logic [7:0] year;
        logic hit;
        // set after a write lands; without it extra bytes in one select would be taken as commands
        logic done;
    } rat_reg_t;

    localparam rat_reg_t RST_VAL = '{
        st: RAT_IDLE,
        sclk: 1'b0,
        bitn: 3'h0,
        sh: 8'h00,
        cmd: 8'h00,
        tx: 8'h00,
        dout: 1'b0,
        oe: 1'b0,
        sel: RST_SEL,
        sec: RST_SEC,
        min: RST_MIN,
        hr: RST_HR,
        date: RST_DATE,
        mon: RST_MON,
        wday: RST_WDAY,
        year: RST_YEAR,
        hit: 1'b0,
        done: 1'b0
    };

    rat_reg_t r_q;
    rat_reg_t r_d;

    // read value of a register code; unmapped codes read zero
    function automatic logic [7:0] rd_mux(input rat_reg_t r, input logic [4:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            REG_MATCH_SEL:
            begin
                v = r.sel & MASK_SEL; // RQ1
            end
            REG_RESERVED:
            begin
                v = RST_RESERVED; // RQ2
            end
            REG_SEC_LIM:
            begin
                v = r.sec & MASK_SEC; // RQ3
            end
            REG_MIN_LIM:
            begin
                v = r.min & MASK_MIN; // RQ3
            end
            REG_HR_LIM:
            begin
                v = r.hr & MASK_HR; // RQ4
            end
            REG_DATE_LIM:
            begin
                v = r.date & MASK_DATE; // RQ6
            end
            REG_MON_LIM:
            begin
                v = r.mon & MASK_MON; // RQ7
            end
            REG_WDAY_LIM:
            begin
                v = r.wday & MASK_WDAY;
            end
            REG_YEAR_LIM:
            begin
                v = r.year & MASK_YEAR; // RQ8
            end
            default:
            begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    logic [NUM_LIM-1:0] fld_ok;
    logic [7:0] lim_v [NUM_LIM];
    logic [7:0] now_v [NUM_LIM];
    logic [7:0] msk_v [NUM_LIM];

    always_comb
    begin
        lim_v[SEL_SEC] = r_q.sec;
        lim_v[SEL_MIN] = r_q.min;
        lim_v[SEL_HR] = r_q.hr;
        lim_v[SEL_DATE] = r_q.date;
        lim_v[SEL_MON] = r_q.mon;
        lim_v[SEL_WDAY] = r_q.wday;
        lim_v[SEL_YEAR] = r_q.year;
        now_v[SEL_SEC] = now_sec;
        now_v[SEL_MIN] = now_min;
        now_v[SEL_HR] = now_hr;
        now_v[SEL_DATE] = now_date;
        now_v[SEL_MON] = now_mon;
        now_v[SEL_WDAY] = now_wday;
        now_v[SEL_YEAR] = now_year;
        msk_v[SEL_SEC] = MASK_SEC;
        msk_v[SEL_MIN] = MASK_MIN;
        msk_v[SEL_HR] = MASK_HR;
        msk_v[SEL_DATE] = MASK_DATE;
        msk_v[SEL_MON] = MASK_MON;
        msk_v[SEL_WDAY] = MASK_WDAY;
        msk_v[SEL_YEAR] = MASK_YEAR;
    end

    // a disabled field always counts as matching
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LIM; gi++)
        begin : g_cmp
            assign fld_ok[gi] = !r_q.sel[gi]
                || ((lim_v[gi] & msk_v[gi]) == (now_v[gi] & msk_v[gi])); // RQ11
        end
    endgenerate

    always_comb
    begin
        logic rise;
        logic fall;
        logic [7:0] nb;
        logic wr_ok;
        r_d = r_q;
        rise = spi_sclk && !r_q.sclk;
        fall = !spi_sclk && r_q.sclk;
        nb = {r_q.sh[6:0], spi_din};
        wr_ok = 1'b0;
        r_d.sclk = spi_sclk;
        // at least one field must be enabled, otherwise reset state would alarm
        r_d.hit = (|r_q.sel[NUM_LIM-1:0]) && (&fld_ok); // RQ11
        case (r_q.st)
            RAT_IDLE:
            begin
                r_d.oe = 1'b0;
                r_d.bitn = 3'h0;
                // after a write the port stays idle until select is released
                if (!spi_cs_n && !r_q.done)
                begin
                    r_d.st = RAT_CMD;
                end
            end
            RAT_CMD:
            begin
                if (rise)
                begin
                    // command shifts in msb first
                    r_d.sh = nb; // RQ9
                    r_d.bitn = r_q.bitn + 3'h1;
                    if (r_q.bitn == BIT_LAST)
                    begin
                        r_d.cmd = nb;
                        r_d.st = RAT_DATA;
                        r_d.tx = (nb[CMD_RAM_BIT]) ? 8'h00
                            : rd_mux(r_q, nb[5:1] & CMD_ADDR_MASK); // RQ9
                    end
                end
            end
            RAT_DATA:
            begin
                // read data is shifted out on falling edges, msb first
                if (r_q.cmd[CMD_RD_BIT] && fall)
                begin
                    r_d.oe = 1'b1;
                    r_d.dout = r_q.tx[7];
                    r_d.tx = {r_q.tx[6:0], 1'b0};
                end
                if (rise)
                begin
                    r_d.sh = nb;
                    r_d.bitn = r_q.bitn + 3'h1;
                    // only the first data byte is taken; burst is not supported here
                    if (r_q.bitn == BIT_LAST && !r_q.cmd[CMD_RD_BIT]
                        && !r_q.cmd[CMD_RAM_BIT] && r_q.cmd[CMD_ONE_BIT]) // RQ9 RQ10
                    begin
                        wr_ok = 1'b1;
                    end
                end
            end
            default:
            begin
                r_d.st = RAT_IDLE;
            end
        endcase
        if (wr_ok)
        begin
            r_d.st = RAT_IDLE;
            r_d.done = 1'b1;
            case (r_q.cmd[5:1])
                REG_MATCH_SEL:
                begin
                    r_d.sel = nb & MASK_SEL; // RQ1
                end
                REG_SEC_LIM:
                begin
                    r_d.sec = nb & MASK_SEC; // RQ3
                end
                REG_MIN_LIM:
                begin
                    r_d.min = nb & MASK_MIN; // RQ3
                end
                REG_HR_LIM:
                begin
                    r_d.hr = nb & MASK_HR; // RQ4
                end
                REG_DATE_LIM:
                begin
                    r_d.date = nb & MASK_DATE; // RQ6
                end
                REG_MON_LIM:
                begin
                    r_d.mon = nb & MASK_MON; // RQ7
                end
                REG_WDAY_LIM:
                begin
                    r_d.wday = nb & MASK_WDAY;
                end
                REG_YEAR_LIM:
                begin
                    r_d.year = nb & MASK_YEAR; // RQ8
                end
                // reserved register is fixed; writes are dropped
                default:
                begin
                    r_d.sel = r_q.sel; // RQ2
                end
            endcase
        end
        if (spi_cs_n)
        begin
            r_d.st = RAT_IDLE;
            r_d.oe = 1'b0;
            r_d.bitn = 3'h0;
            r_d.done = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q <= RST_VAL; // RQ1 RQ5 RQ7 RQ8
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign spi_dout = r_q.dout;
    assign spi_dout_oe = r_q.oe;
    assign alarm_hit = r_q.hit;
endmodule

// ==== verif/rat_alarm_regs_checker.sv ====
// port checker for the alarm threshold register block
// assumes one clock domain; serial pins already synchronous to core_clk
module rat_alarm_regs_checker
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic spi_cs_n, // select
    input wire logic spi_sclk, // serial clock
    input wire logic spi_din, // data in
    input wire logic spi_dout, // data out
    input wire logic spi_dout_oe, // out enable
    input wire logic alarm_hit // alarm level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sclk_q;
    logic rd_q;
    logic [4:0] rise_q;
    wire logic rise = spi_sclk && !sclk_q && !spi_cs_n;
    wire logic fall = sclk_q && !spi_sclk;
    // no reset needed: idle select clears the count before any frame
    always_ff @(posedge core_clk)
    begin
        sclk_q <= spi_sclk;
        rise_q <= spi_cs_n ? 5'h00 : rise_q + {4'h0, rise && rise_q != 5'h1F};
        if (rise && rise_q == 5'h00)
            rd_q <= spi_din;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_idle;
        spi_cs_n ##1 spi_cs_n;
    endsequence
    a_oe_idle_off: assert property (s_idle |-> !spi_dout_oe)
        else $error("dout enabled outside a frame");
    a_oe_holds_on: assert property (spi_dout_oe && !spi_cs_n |=> spi_dout_oe)
        else $error("dout enable dropped in frame");
    a_oe_drops_late: assert property (spi_dout_oe && spi_cs_n |=> !spi_dout_oe)
        else $error("dout enable held after select");
    a_dout_on_fall: assert property (spi_dout_oe && $changed(spi_dout) |-> $past(fall))
        else $error("dout moved without a clock fall");
    a_oe_after_cmd: assert property ($rose(spi_dout_oe) |-> rise_q == 5'h08)
        else $error("dout enabled before command end");
    a_oe_read_only: assert property ($rose(spi_dout_oe) |-> rd_q)
        else $error("dout enabled on a write");
    a_no_oe_early: assert property (!spi_cs_n && rise_q < 5'h08 |-> !spi_dout_oe)
        else $error("dout enabled in command byte");
    a_reset_quiet: assert property ($rose(rst_n) |-> !spi_dout_oe && !alarm_hit)
        else $error("outputs active out of reset");
endmodule
bind rat_alarm_regs rat_alarm_regs_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_din(spi_din), .spi_dout(spi_dout),
    .spi_dout_oe(spi_dout_oe), .alarm_hit(alarm_hit));

// ==== verif/rat_host_model.sv ====
// serial host model: one command byte and one data byte per frame
// assumes the block samples its serial pins on core_clk rising edges
module rat_host_model
(
    input wire logic core_clk, // clock
    input wire logic spi_dout, // data from block
    output logic spi_cs_n, // select, active low
    output logic spi_sclk, // serial clock, still between frames
    output logic spi_din // data to block
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_din = 1'b0;
    end
    // hp sets the half period in core_clk cycles, so slow hosts can be mimicked
    task automatic xfer(input logic [7:0] c, input logic [7:0] w, input int hp,
        output logic [7:0] r);
        logic [15:0] s;
        s = {c, w};
        @(negedge core_clk);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spi_din = s[i];
            repeat (hp) @(negedge core_clk);
            if (i < 8)
                r[i] = spi_dout;
            spi_sclk = 1'b1;
            repeat (hp) @(negedge core_clk);
            spi_sclk = 1'b0;
        end
        repeat (hp) @(negedge core_clk);
        spi_cs_n = 1'b1;
        spi_din = ~spi_din;
        repeat (hp) @(negedge core_clk);
    endtask
endmodule

// ==== verif/test_rtc_alarm_threshold_regs.sv ====
// bench for the alarm threshold registers: reset values, field widths, refusals, alarm
// assumes the host model drives the serial pins; the bench drives the time fields
module test_rtc_alarm_threshold_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import rat_pkg::*;
    localparam logic [4:0] CODES [9] = '{REG_MATCH_SEL, REG_RESERVED, REG_SEC_LIM,
        REG_MIN_LIM, REG_HR_LIM, REG_DATE_LIM, REG_MON_LIM, REG_WDAY_LIM, REG_YEAR_LIM};
    localparam logic [7:0] RSTV [9] = '{RST_SEL, RST_RESERVED, RST_SEC, RST_MIN, RST_HR,
        RST_DATE, RST_MON, RST_WDAY, RST_YEAR};
    localparam logic [7:0] MSKV [9] = '{MASK_SEL, RST_RESERVED, MASK_SEC, MASK_MIN, MASK_HR,
        MASK_DATE, MASK_MON, MASK_WDAY, MASK_YEAR};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sclk, din, dout, oe, hit;
    logic [7:0] now_v [7] = '{default: 8'h00};
    logic [7:0] r;
    int n_mismatch = 0;
    int n_tests = 0;
    // a released line shows the inverse, so an undriven read cannot pass as zero
    wire logic line = oe ? dout : ~dout;
    always #2.5 core_clk = ~core_clk;
    rat_alarm_regs u_rat_alarm_regs (.core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(cs_n),
        .spi_sclk(sclk), .spi_din(din), .spi_dout(dout), .spi_dout_oe(oe), .now_sec(now_v[0]),
        .now_min(now_v[1]), .now_hr(now_v[2]), .now_date(now_v[3]), .now_mon(now_v[4]),
        .now_wday(now_v[5]), .now_year(now_v[6]), .alarm_hit(hit));
    rat_host_model u_rat_host_model (.core_clk(core_clk), .spi_dout(line), .spi_cs_n(cs_n),
        .spi_sclk(sclk), .spi_din(din));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        u_rat_host_model.xfer(c, d, 5, x);
    endtask
    task automatic hit_chk(input logic e);
        repeat (3) @(negedge core_clk);
        chk("alarm level", {7'h00, e}, {7'h00, hit});
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        // the tests need about 5000 cycles; four times that before giving up
        #100000;
        n_mismatch++;
        conclude();
    end
    initial
    begin
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            u_rat_host_model.xfer({2'b10, CODES[i], 1'b1}, 8'h00, 3, r);
            chk("reset value", RSTV[i], r);
            if (i != 1)
                wr({2'b00, CODES[i], 1'b1}, 8'hFF);
        end
        $display("test reset values done");
        for (int i = 0; i < 9; i++)
        begin
            u_rat_host_model.xfer({2'b10, CODES[i], 1'b1}, 8'h00, 3, r);
            chk("field width", MSKV[i], r);
        end
        $display("test field widths done");
        wr({2'b00, REG_SEC_LIM, 1'b0}, 8'h00);
        wr({2'b01, REG_SEC_LIM, 1'b1}, 8'h00);
        u_rat_host_model.xfer({2'b10, REG_SEC_LIM, 1'b1}, 8'h00, 3, r);
        chk("refused write", MASK_SEC, r);
        u_rat_host_model.xfer({2'b11, REG_SEC_LIM, 1'b1}, 8'h00, 3, r);
        chk("ram read", 8'h00, r);
        $display("test refused writes done");
        wr({2'b00, REG_SEC_LIM, 1'b1}, 8'h59);
        wr({2'b00, REG_HR_LIM, 1'b1}, 8'hA5);
        wr({2'b00, REG_MATCH_SEL, 1'b1}, 8'h05);
        u_rat_host_model.xfer({2'b10, REG_HR_LIM, 1'b1}, 8'h00, 3, r);
        chk("pm hours", 8'hA5, r);
        now_v[0] = 8'h59;
        now_v[2] = 8'hA5;
        hit_chk(1'b1);
        now_v[2] = 8'h85;
        hit_chk(1'b0);
        now_v[2] = 8'hA5;
        wr({2'b00, REG_MATCH_SEL, 1'b1}, 8'h00);
        hit_chk(1'b0);
        // every limit now holds its masked all-ones write except seconds and hours
        now_v = '{8'h59, MASK_MIN, 8'hA5, MASK_DATE, MASK_MON, MASK_WDAY, MASK_YEAR};
        wr({2'b00, REG_MATCH_SEL, 1'b1}, MASK_SEL);
        hit_chk(1'b1);
        for (int j = 0; j < NUM_LIM; j++)
        begin
            now_v[j] = now_v[j] ^ 8'h01;
            hit_chk(1'b0);
            now_v[j] = now_v[j] ^ 8'h01;
        end
        $display("test alarm match done");
        conclude();
    end
endmodule
